// ### src/lse_ctrl.sv
/*
  LCD sleep/enable controller: Wishbone registers, frame-end shutdown,
  sleep behaviour per clock source, interrupt and wake generation.
  Assumes sleep_i is a level from the core that is high while it sleeps.
*/
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
module lse_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire logic        sleep_i,
  output logic             wake_o,
  output logic             irq_o,
  output logic [3:0]       com_o,
  output logic [31:0]      seg_o,
  output logic [3:0]       com_oe_o,
  output logic [31:0]      seg_oe_o
);
  localparam int unsigned PIX_W = 5;
  logic [7:0]            ctrl_ff;
  logic [7:0]            ps_ff;
  logic [31:0]           segen_ff;
  logic [lse_pkg::ST_W-1:0] stat_ff;
  logic [lse_pkg::ST_W-1:0] ien_ff;
  logic [7:0]            pix_ff [lse_pkg::NUM_PIX*2];
  logic [lse_pkg::NUM_COM*lse_pkg::NUM_SEG-1:0] pix_flat;
  lse_pkg::lse_state_t   state_ff;
  lse_pkg::lse_state_t   nxt_state;
  lse_pkg::lse_cfg_t     cfg;
  lse_pkg::lse_pins_t    wave_pins;
  logic                  active_ff;
  logic                  wb_req;
  logic                  wb_wr;
  logic                  pix_hit;
  logic [PIX_W-1:0]      pix_idx;
  logic                  run;
  logic                  tick;
  logic                  frame_start;
  logic                  odd_frame;
  logic                  frame_irq_ok;
  logic                  shut_evt;
  logic                  frame_evt;

  assign cfg.en       = ctrl_ff[lse_pkg::CTL_EN];
  assign cfg.slp_dis  = ctrl_ff[lse_pkg::CTL_SLP];
  assign cfg.clk_src  = ctrl_ff[lse_pkg::CTL_CS_HI:lse_pkg::CTL_CS_LO];
  assign cfg.mux      = ctrl_ff[lse_pkg::CTL_MX_HI:lse_pkg::CTL_MX_LO];
  assign cfg.wft_b    = ps_ff[lse_pkg::PS_WFT];
  assign cfg.prescale = ps_ff[lse_pkg::PS_LP_HI:lse_pkg::PS_LP_LO];

  // Bus decode; every access is answered one cycle after the request
  assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr   = wb_req && wb_we_i && wb_sel_i[0];
  assign pix_hit = (wb_adr_i >= lse_pkg::ADR_PIX0) && (wb_adr_i <= lse_pkg::ADR_PIXN);
  assign pix_idx = PIX_W'((wb_adr_i - lse_pkg::ADR_PIX0) >> lse_pkg::PIX_IDX_LSB);

  // Wave engine runs unless sleep stops it per source and sleep-disable bit
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      lse_pkg::LSE_OFF: begin
        if (cfg.en && !sleep_i) begin
          nxt_state = lse_pkg::LSE_RUN;
        end
      end
      lse_pkg::LSE_RUN: begin
        if (sleep_i && cfg.slp_dis) begin
          nxt_state = lse_pkg::LSE_STOP;
        end else if (sleep_i && cfg.clk_src == lse_pkg::CS_SYSDIV4) begin
          nxt_state = lse_pkg::LSE_HALT;
        end else if (!cfg.en && frame_start) begin
          nxt_state = lse_pkg::LSE_OFF;
        end
      end
      lse_pkg::LSE_STOP: begin
        if (!sleep_i) begin
          nxt_state = cfg.en ? lse_pkg::LSE_RUN : lse_pkg::LSE_OFF;
        end
      end
      lse_pkg::LSE_HALT: begin
        if (!sleep_i) begin
          nxt_state = lse_pkg::LSE_RUN;
        end
      end
      default: nxt_state = lse_pkg::LSE_OFF;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= lse_pkg::LSE_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // in sleep with a slow source and bit clear the engine keeps running
  assign run = (state_ff == lse_pkg::LSE_RUN);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_ff <= 1'b0;
    end else begin
      active_ff <= (nxt_state != lse_pkg::LSE_OFF);
    end
  end

  assign shut_evt     = active_ff && (nxt_state == lse_pkg::LSE_OFF);
  assign frame_irq_ok = cfg.wft_b && (cfg.mux != lse_pkg::MUX_STATIC);
  assign frame_evt    = run && frame_start && odd_frame && frame_irq_ok;

  // Sticky status; a set in the same cycle as a clear wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= (stat_ff & ~((wb_wr && wb_adr_i == lse_pkg::ADR_CLR) ?
                 wb_dat_i[lse_pkg::ST_W-1:0] : '0)) |
                 {frame_evt, shut_evt};
    end
  end

  assign irq_o  = |(stat_ff & ien_ff);
  assign wake_o = sleep_i && stat_ff[lse_pkg::ST_FRAME] && ien_ff[lse_pkg::ST_FRAME];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= lse_pkg::CTRL_RST;
    end else if (wb_wr && wb_adr_i == lse_pkg::ADR_CTRL) begin
      ctrl_ff <= {wb_dat_i[7:6], ctrl_ff[lse_pkg::CTL_WERR] & ~wb_dat_i[5], 1'b0,
                  wb_dat_i[3:0]};
    end else if (wb_wr && pix_hit && sleep_i) begin
      ctrl_ff[lse_pkg::CTL_WERR] <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ps_ff    <= lse_pkg::PS_RST;
      segen_ff <= '0;
      ien_ff   <= '0;
    end else if (wb_wr) begin
      if (wb_adr_i == lse_pkg::ADR_PS) begin
        ps_ff <= {wb_dat_i[7:6], 2'h0, wb_dat_i[3:0]};
      end
      if (wb_adr_i == lse_pkg::ADR_SEGEN) begin
        segen_ff <= wb_dat_i;
      end
      if (wb_adr_i == lse_pkg::ADR_IEN) begin
        ien_ff <= wb_dat_i[lse_pkg::ST_W-1:0];
      end
    end
  end

  // Pixel store, one byte per word; writes refused while sleeping
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < lse_pkg::NUM_PIX*2; i++) begin
        pix_ff[i] <= 8'h00;
      end
    end else if (wb_wr && pix_hit && !sleep_i) begin
      pix_ff[pix_idx] <= wb_dat_i[7:0];
    end
  end

  always_comb begin
    pix_flat = '0;
    for (int c = 0; c < lse_pkg::NUM_COM; c++) begin
      // Three words per common so every common is reachable; top byte stays clear
      for (int b = 0; b < 3; b++) begin
        pix_flat[c*lse_pkg::NUM_SEG + b*8 +: 8] = pix_ff[c*3 + b];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_err_o <= 1'b0;
      wb_dat_o <= '0;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == lse_pkg::ADR_CTRL) begin
          wb_dat_o <= {24'h0000_00, ctrl_ff};
        end else if (wb_adr_i == lse_pkg::ADR_PS) begin
          wb_dat_o <= {24'h0000_00, ps_ff[7:6], active_ff, 1'b0, ps_ff[3:0]};
        end else if (wb_adr_i == lse_pkg::ADR_SEGEN) begin
          wb_dat_o <= segen_ff;
        end else if (wb_adr_i == lse_pkg::ADR_STAT) begin
          wb_dat_o <= {30'h0000_0000, stat_ff};
        end else if (wb_adr_i == lse_pkg::ADR_IEN) begin
          wb_dat_o <= {30'h0000_0000, ien_ff};
        end else if (pix_hit) begin
          wb_dat_o <= {24'h0000_00, pix_ff[pix_idx]};
        end
      end
    end
  end

  lse_tick u_tick (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .run_i      (run),
    .prescale_i (cfg.prescale),
    .tick_o     (tick)
  );

  lse_wave u_wave (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .run_i         (run),
    .tick_i        (tick),
    .mux_i         (cfg.mux),
    .pix_i         (pix_flat),
    .frame_start_o (frame_start),
    .odd_frame_o   (odd_frame),
    .pins_o        (wave_pins)
  );

  // Pin drive: grounded in stop, held in halt, released when off
  always_comb begin
    com_o    = wave_pins.com;
    seg_o    = wave_pins.seg;
    com_oe_o = '1;
    seg_oe_o = segen_ff;
    if (state_ff == lse_pkg::LSE_STOP) begin
      com_o = '0;
      seg_o = '0;
    end else if (state_ff == lse_pkg::LSE_OFF) begin
      com_oe_o = '0;
      seg_oe_o = '0;
    end
  end
endmodule // lse_ctrl

// ### common/lse_pkg.sv
/*
  Constants, register map and carrier types of the LCD sleep/enable controller.
  Assumes a classic Wishbone slave with 32-bit data and one 100 MHz clock.
*/
package lse_pkg;
  localparam int unsigned NUM_COM  = 4;
  localparam int unsigned NUM_SEG  = 32;
  localparam int unsigned NUM_PIX  = 12;
  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_PS    = 8'h04;
  localparam logic [7:0] ADR_SEGEN = 8'h08;
  localparam logic [7:0] ADR_STAT  = 8'h0C;
  localparam logic [7:0] ADR_CLR   = 8'h10;
  localparam logic [7:0] ADR_IEN   = 8'h14;
  localparam logic [7:0] ADR_PIX0  = 8'h40;
  localparam logic [7:0] ADR_PIXN  = 8'h6C;
  localparam int unsigned PIX_IDX_LSB = 2;
  localparam int unsigned PIX_IDX_W   = 4;
  // Control register fields
  localparam int unsigned CTL_EN    = 7;
  localparam int unsigned CTL_SLP   = 6;
  localparam int unsigned CTL_WERR  = 5;
  localparam int unsigned CTL_CS_HI = 3;
  localparam int unsigned CTL_CS_LO = 2;
  localparam int unsigned CTL_MX_HI = 1;
  localparam int unsigned CTL_MX_LO = 0;
  // Prescale register fields
  localparam int unsigned PS_WFT    = 7;
  localparam int unsigned PS_ACT    = 5;
  localparam int unsigned PS_LP_HI  = 3;
  localparam int unsigned PS_LP_LO  = 0;
  // Status bits
  localparam int unsigned ST_SHUT   = 0;
  localparam int unsigned ST_FRAME  = 1;
  localparam int unsigned ST_W      = 2;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] PS_RST     = 8'h00;
  localparam logic [1:0] CS_SYSDIV4 = 2'h0;
  localparam logic [1:0] CS_TIMER1_CRYSTAL_OSC   = 2'h1;
  localparam logic [1:0] CS_LFINT   = 2'h2;
  localparam logic [1:0] MUX_STATIC = 2'h0;
  // Base tick: one phase step per 10 us at prescale 0
  localparam int unsigned TICK_NS     = 10000;
  localparam int unsigned CLK_NS      = 10;
  localparam int unsigned TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int unsigned TICK_W      = 10;
  typedef enum logic [3:0] {
    LSE_OFF    = 4'h1,
    LSE_RUN    = 4'h2,
    LSE_STOP   = 4'h4,
    LSE_HALT   = 4'h8
  } lse_state_t;
  typedef struct packed {
    logic        en;
    logic        slp_dis;
    logic [1:0]  clk_src;
    logic [1:0]  mux;
    logic        wft_b;
    logic [3:0]  prescale;
  } lse_cfg_t;
  typedef struct packed {
    logic [NUM_COM-1:0] com;
    logic [NUM_SEG-1:0] seg;
  } lse_pins_t;
endpackage : lse_pkg

// ### src/lse_tick.sv
/*
  Phase tick divider: one-cycle enable every (prescale+1) base ticks.
  Assumes a synchronous, active-high reset and a running enable input.
*/
`timescale 1ns/100ps
module lse_tick (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic [3:0] prescale_i,
  output logic            tick_o
);
  logic [lse_pkg::TICK_W-1:0] base_ff;
  logic [3:0]                 pre_ff;
  logic                       base_end;
  assign base_end = (base_ff == lse_pkg::TICK_W'(lse_pkg::TICK_CYCLES - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i || base_end) begin
      base_ff <= '0;
    end else begin
      base_ff <= base_ff + 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      pre_ff <= '0;
      tick_o <= 1'b0;
    end else if (base_end) begin
      tick_o <= (pre_ff == prescale_i);
      pre_ff <= (pre_ff == prescale_i) ? 4'h0 : pre_ff + 4'h1;
    end else begin
      tick_o <= 1'b0;
    end
  end
endmodule // lse_tick

// ### src/lse_wave.sv
/*
  Common and segment level generator (digital two-level model of the drive).
  Steps one phase per tick; frame length is the number of commons in use.
*/
`timescale 1ns/100ps
module lse_wave (
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  input  wire logic                            run_i,
  input  wire logic                            tick_i,
  input  wire logic [1:0]                      mux_i,
  input  wire logic [lse_pkg::NUM_COM*lse_pkg::NUM_SEG-1:0] pix_i,
  output logic                                 frame_start_o,
  output logic                                 odd_frame_o,
  output lse_pkg::lse_pins_t                   pins_o
);
  logic [1:0] com_ff;
  logic       last_com;
  assign last_com = (com_ff == mux_i);
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      com_ff        <= 2'h0;
      odd_frame_o   <= 1'b0;
      frame_start_o <= 1'b0;
    end else if (tick_i) begin
      com_ff        <= last_com ? 2'h0 : com_ff + 2'h1;
      frame_start_o <= last_com;
      if (last_com) begin
        odd_frame_o <= ~odd_frame_o;
      end
    end else begin
      frame_start_o <= 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_o <= '0;
    end else if (run_i && tick_i) begin
      pins_o.com <= lse_pkg::NUM_COM'(1) << (last_com ? 2'h0 : com_ff + 2'h1);
      pins_o.seg <= pix_i[(last_com ? 2'h0 : com_ff + 2'h1)*lse_pkg::NUM_SEG +: lse_pkg::NUM_SEG];
    end
  end
endmodule // lse_wave

// ### testbench/lse_properties.sv
/*
  Port checker of lse_ctrl, bound to every instance.
  Assumes ctrl and prescale are not rewritten while the core sleeps.
*/
`timescale 1ns/100ps
module lse_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic        sleep_i,
  input wire logic        wake_o,
  input wire logic        irq_o,
  input wire logic [3:0]  com_o,
  input wire logic [31:0] seg_o,
  input wire logic [3:0]  com_oe_o,
  input wire logic [31:0] seg_oe_o
);
  localparam int MAXF = 64010;
  logic [7:0] ctl_ff;
  logic [7:0] ps_ff;
  logic [7:0] ien_ff;
  int         off_ff;
  logic       wr;
  assign wr = wb_ack_o & wb_we_i & wb_sel_i[0];
  // Shadow of the control, prescale and enable registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_ff <= 8'h00;
      ps_ff  <= 8'h00;
      ien_ff <= 8'h00;
    end else if (wr) begin
      if (wb_adr_i == lse_pkg::ADR_CTRL) ctl_ff <= wb_dat_i[7:0];
      if (wb_adr_i == lse_pkg::ADR_PS) ps_ff <= wb_dat_i[7:0];
      if (wb_adr_i == lse_pkg::ADR_IEN) ien_ff <= wb_dat_i[7:0];
    end
  end
  // Cycles since the enable was cleared while the pins are still driven
  always_ff @(posedge clk_i) begin
    if (rst_i) off_ff <= 0;
    else if (wr && wb_adr_i == lse_pkg::ADR_CTRL) off_ff <= int'(!wb_dat_i[7]);
    else if (com_oe_o == 4'h0) off_ff <= 0;
    else if (off_ff != 0) off_ff <= off_ff + 1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_slept;
    sleep_i ##1 sleep_i ##1 sleep_i;
  endsequence
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_err_never: assert property (!wb_err_o)
    else $error("error response seen");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:5] == 3'h1
    |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  a_stop_ground: assert property (sleep_i ##1 sleep_i && ctl_ff[6]
    |-> com_o == 4'h0 && seg_o == 32'h0000_0000) else $error("lines not grounded in sleep");
  a_halt_hold: assert property (s_slept ##0 (ctl_ff[3:2] == lse_pkg::CS_SYSDIV4 && !ctl_ff[6])
    |-> $stable(com_o) && $stable(seg_o)) else $error("pins moved while halted");
  a_wake_frame_only: assert property (wake_o
    |-> sleep_i && ps_ff[7] && ctl_ff[1:0] != lse_pkg::MUX_STATIC)
    else $error("wake without frame interrupt conditions");
  a_shut_irq: assert property ($fell(|com_oe_o) && ien_ff[0] |-> ##[0:1] irq_o)
    else $error("no interrupt when shutdown completed");
  a_release_bound: assert property (off_ff <= MAXF)
    else $error("pins not released within a frame");
  a_irq_masked: assert property (ien_ff[2:0] == 3'h0 |-> !irq_o)
    else $error("interrupt while all sources masked");
endmodule // lse_properties
bind lse_ctrl lse_properties i_props (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .sleep_i(sleep_i), .wake_o(wake_o), .irq_o(irq_o), .com_o(com_o), .seg_o(seg_o),
  .com_oe_o(com_oe_o), .seg_oe_o(seg_oe_o));

// ### testbench/lse_glass.sv
/*
  Glass and port side of the display pins: wire levels seen by the panel.
  Assumes the port drives every released display pin low.
*/
`timescale 1ns/100ps
module lse_glass (
  input wire logic [3:0]  com_i,
  input wire logic [31:0] seg_i,
  input wire logic [3:0]  com_oe_i,
  input wire logic [31:0] seg_oe_i,
  output logic [3:0]      com_w_o,
  output logic [31:0]     seg_w_o
);
  assign com_w_o = com_i & com_oe_i;
  assign seg_w_o = seg_i & seg_oe_i;
endmodule // lse_glass

// ### testbench/testbench.sv
/*
  Self-checking bench of lse_ctrl with a pixel register model in one queue.
  Assumes one 100 MHz clock and the glass model on the pins.
*/
`timescale 1ns/100ps
module testbench;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [3:0]  wb_sel_i = 4'hf;
  logic        wb_we_i  = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        sleep_i  = 1'b0;
  logic [31:0] wb_dat_o, seg_o, seg_oe_o, seg_w, s0, rd;
  logic [31:0] seed     = 32'h0000_cdd2;
  logic [3:0]  com_o, com_oe_o, com_w, c0;
  logic        wb_ack_o, wb_err_o, wake_o, irq_o;
  logic [7:0]  pix_m[$];
  int          num_errors  = 0;
  int          comparisons = 0;
  int          n;
  always #5 clk_i = ~clk_i;
  lse_ctrl i_lse_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .sleep_i(sleep_i),
    .wake_o(wake_o), .irq_o(irq_o), .com_o(com_o), .seg_o(seg_o), .com_oe_o(com_oe_o),
    .seg_oe_o(seg_oe_o));
  lse_glass i_lse_glass (.com_i(com_o), .seg_i(seg_o), .com_oe_i(com_oe_o),
    .seg_oe_i(seg_oe_o), .com_w_o(com_w), .seg_w_o(seg_w));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic test_done;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      num_errors++;
      $display("Wait limit reached");
      test_done();
    end
  endtask
  // Classic single cycle, entered just after a rising edge
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    wb_adr_i <= a;
    wb_we_i  <= w;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    tmo((wb_ack_o === 1'b1) ? 0 : k, 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    wb(a, 1'b0, 32'h0000_0000);
    check(nm, rd, exp);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc("ctrl", lse_pkg::ADR_CTRL, 32'h0000_0000);
    rdc("unmapped", 8'h20, 32'h0000_0000);
    check("released", {28'h0, com_oe_o}, 32'h0000_0000);
    $display("Test reset done");
    wb(lse_pkg::ADR_PS, 1'b1, 32'h0000_0080);
    wb(lse_pkg::ADR_SEGEN, 1'b1, 32'hffff_ffff);
    wb(lse_pkg::ADR_CTRL, 1'b1, 32'h0000_000b);
    for (n = 0; n < lse_pkg::NUM_PIX; n++) begin
      seed = xs(seed);
      pix_m.push_back(seed[7:0]);
      wb(lse_pkg::ADR_PIX0 + 8'(4 * n), 1'b1, seed);
    end
    wb(lse_pkg::ADR_CLR, 1'b1, 32'h0000_0003);
    wb(lse_pkg::ADR_IEN, 1'b1, 32'h0000_0003);
    wb(lse_pkg::ADR_CTRL, 1'b1, 32'h0000_008b);
    rdc("active", lse_pkg::ADR_PS, 32'h0000_00a0);
    check("driving", {31'h0, |com_oe_o}, 32'h0000_0001);
    $display("Test enable done");
    sleep_i <= 1'b1;
    wb(lse_pkg::ADR_PIX0, 1'b1, {24'h0, ~pix_m[0]});
    rdc("write error", lse_pkg::ADR_CTRL, 32'h0000_00ab);
    rdc("pixel held", lse_pkg::ADR_PIX0, {24'h0, pix_m[0]});
    for (n = 0; n < 9000 && wake_o !== 1'b1; n++) @(posedge clk_i);
    tmo(n, 9000);
    check("running asleep", {31'h0, |com_oe_o}, 32'h0000_0001);
    check("first common", {28'h0, com_o}, 32'h0000_0001);
    check("shown pixels", seg_o, {8'h00, pix_m[2], pix_m[1], pix_m[0]});
    sleep_i <= 1'b0;
    @(posedge clk_i);
    wb(lse_pkg::ADR_CLR, 1'b1, 32'h0000_0002);
    $display("Test sleep run done");
    wb(lse_pkg::ADR_CTRL, 1'b1, 32'h0000_0000);
    check("frame finishing", {31'h0, |com_oe_o}, 32'h0000_0001);
    rd = 32'h0000_0000;
    for (n = 0; n < 2000 && rd[0] !== 1'b1; n++) wb(lse_pkg::ADR_STAT, 1'b0, 32'h0000_0000);
    tmo(n, 2000);
    check("shutdown status", rd, 32'h0000_0001);
    check("shutdown irq", {31'h0, irq_o}, 32'h0000_0001);
    check("pins released", {31'h0, |{com_oe_o, seg_oe_o}}, 32'h0000_0000);
    check("glass low", {28'h0, com_w} | seg_w, 32'h0000_0000);
    rdc("inactive", lse_pkg::ADR_PS, 32'h0000_0080);
    wb(lse_pkg::ADR_CLR, 1'b1, 32'h0000_0003);
    check("irq cleared", {31'h0, irq_o}, 32'h0000_0000);
    $display("Test disable done");
    wb(lse_pkg::ADR_PS, 1'b1, 32'h0000_0000);
    wb(lse_pkg::ADR_CTRL, 1'b1, 32'h0000_0083);
    repeat (8500) @(posedge clk_i);
    sleep_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    c0 = com_o;
    s0 = seg_o;
    repeat (3000) @(posedge clk_i);
    check("halt com", {28'h0, com_o}, {28'h0, c0});
    check("halt seg", seg_o, s0);
    rdc("no frame irq", lse_pkg::ADR_STAT, 32'h0000_0000);
    sleep_i <= 1'b0;
    wb(lse_pkg::ADR_CTRL, 1'b1, 32'h0000_00c3);
    $display("Test halt done");
    repeat (100) @(posedge clk_i);
    sleep_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check("stop lines", {28'h0, com_o} | seg_o, 32'h0000_0000);
    sleep_i <= 1'b0;
    wb(lse_pkg::ADR_CTRL, 1'b1, 32'h0000_0000);
    $display("Test stop done");
    test_done();
  end
endmodule // testbench
